// *** spdr_defs.vh ***
// Purpose: constants for the SIMD prefix decode and register map block
// Assumes: byte-wide prefix codes, 125 MHz core clock
// Notes:   included by spdr_decode.v
`ifndef SPDR_DEFS_VH
`define SPDR_DEFS_VH

// ----------------------------------------------------------------
// Prefix byte codes
// ----------------------------------------------------------------
`define SPDR_PFX_LOCK      8'hF0
`define SPDR_PFX_ADDR      8'h67
`define SPDR_PFX_OPSZ      8'h66
`define SPDR_PFX_REP       8'hF3
`define SPDR_PFX_REPNE     8'hF2
`define SPDR_PFX_SEG_CS    8'h2E
`define SPDR_PFX_SEG_SS    8'h36
`define SPDR_PFX_SEG_DS    8'h3E
`define SPDR_PFX_SEG_ES    8'h26
`define SPDR_PFX_SEG_FS    8'h64
`define SPDR_PFX_SEG_GS    8'h65
`define SPDR_REX_HI        4'h4

// ----------------------------------------------------------------
// Register extension prefix fields
// ----------------------------------------------------------------
`define SPDR_OPERAND_WIDTH_BIT_BIT     3
`define SPDR_REX_R_BIT     2
`define SPDR_REX_B_BIT     0

// ----------------------------------------------------------------
// Feature query
// ----------------------------------------------------------------
`define SPDR_FQ_LEAF       32'h00000001
`define SPDR_FQ_EDX_BIT    25

// ----------------------------------------------------------------
// Segment select codes
// ----------------------------------------------------------------
`define SPDR_SEG_ES        3'h0
`define SPDR_SEG_CS        3'h1
`define SPDR_SEG_SS        3'h2
`define SPDR_SEG_DS        3'h3
`define SPDR_SEG_FS        3'h4
`define SPDR_SEG_GS        3'h5

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define SPDR_MODE_REAL     2'h0
`define SPDR_MODE_PROT     2'h1
`define SPDR_MODE_V86      2'h2
`define SPDR_MODE_LONG     2'h3

// ----------------------------------------------------------------
// Reset values, reserved-bit mask and tag states
// ----------------------------------------------------------------
`define SPDR_CSR_RST       32'h00001F80
`define SPDR_CSR_RSVD_MASK 32'hFFFF0000
`define SPDR_TAG_EMPTY     16'hFFFF
`define SPDR_TAG_VALID     16'h0000
`define SPDR_TOP_ZERO      3'h0

`endif

// *** spdr_decode.v ***
// Purpose: prefix decode and register view for packed and wide SIMD
// Assumes: one prefix byte per cycle, then one opcode strobe per instr
// Notes:   register contents live here; datapath supplies results
`timescale 1ns/100ps
`default_nettype none
`include "spdr_defs.vh"

// What this block does
// - Lock prefix on packed-integer instruction raises invalid-opcode fault.
// - Address-size prefix alters addressing for memory forms; reserved otherwise.
// - Segment override selects segment for memory forms; reserved otherwise.
// - Feature query leaf one reports wide extension in EDX bit 25.
// - Eight 128-bit wide registers, sixteen in 64-bit mode.
// - Wide registers eight to fifteen need the extension prefix index bit.
// - Meaningless extension prefix is ignored without any fault.
// - Width bit selects 64-bit general registers for wide instructions.
// - Scalar single operations touch only the lowest doubleword.
// - One 32-bit SIMD control and status register, saveable and restorable.
// - Eight 64-bit packed-integer registers, separate from the wide registers.
// - Packed-integer registers and tags share floating-point stack storage.
// - Memory addresses come only from general registers, never SIMD ones.
// - Some wide compares write their result into the flags register.
// - Compatibility mode behaves exactly as protected mode.
// - Wide instructions run in protected, real and virtual-8086 modes.
// - Packed-integer instruction except empty-state clears top and tags valid.
module spdr_decode (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [1:0]   mode_i,
  input  wire         compat_i,
  input  wire         pfx_vld_i,
  input  wire [7:0]   pfx_byte_i,
  input  wire         op_vld_i,
  input  wire         op_pint_i,
  input  wire         op_wide_i,
  input  wire         op_empty_i,
  input  wire         op_mem_i,
  input  wire         op_gpr_i,
  input  wire         op_scalar_i,
  input  wire         op_cmp_i,
  input  wire         op_csr_ld_i,
  input  wire         op_csr_st_i,
  input  wire [2:0]   op_reg_i,
  input  wire [2:0]   op_rm_i,
  input  wire         wr_en_i,
  input  wire [127:0] wr_data_i,
  input  wire [31:0]  csr_wdata_i,
  input  wire [31:0]  flags_in_i,
  input  wire [31:0]  flags_res_i,
  input  wire         fq_vld_i,
  input  wire [31:0]  fq_leaf_i,
  output reg          ud_fault_o,
  output reg          gp_fault_o,
  output reg          rsvd_pfx_o,
  output reg          addr_ovr_o,
  output reg          seg_ovr_o,
  output reg  [2:0]   seg_sel_o,
  output reg  [3:0]   dst_idx_o,
  output reg          gpr64_o,
  output reg          addr_from_gpr_o,
  output reg  [127:0] rd_data_o,
  output reg  [31:0]  flags_o,
  output reg          flags_wr_o,
  output reg  [31:0]  fq_edx_o,
  output reg  [31:0]  csr_o,
  output reg  [2:0]   top_o,
  output reg  [15:0]  tag_o,
  output wire         dec_rdy_o
);

  // ----------------------------------------------------------------
  // Prefix collection
  // ----------------------------------------------------------------
  reg         lock_ff;
  reg         addr_ff;
  reg         seg_ff;
  reg  [2:0]  seg_id_ff;
  reg         rsvd_ff;
  reg         rex_ff;
  reg  [3:0]  rex_bits_ff;

  wire        hit_lock;
  wire        hit_addr;
  wire        hit_opsz;
  wire        hit_rep;
  wire        hit_repne;
  wire        hit_es;
  wire        hit_cs;
  wire        hit_ss;
  wire        hit_ds;
  wire        hit_fs;
  wire        hit_gs;
  wire        is_seg = hit_es | hit_cs | hit_ss | hit_ds | hit_fs | hit_gs;
  reg  [2:0]  seg_code;
  wire        long_mode = (mode_i == `SPDR_MODE_LONG) && !compat_i;
  // Extension prefix only decodes in 64-bit mode; elsewhere 4xH is not a prefix
  wire        is_rex = long_mode && (pfx_byte_i[7:4] == `SPDR_REX_HI);

  always @* begin
    case (pfx_byte_i)
      `SPDR_PFX_SEG_ES: seg_code = `SPDR_SEG_ES;
      `SPDR_PFX_SEG_CS: seg_code = `SPDR_SEG_CS;
      `SPDR_PFX_SEG_SS: seg_code = `SPDR_SEG_SS;
      `SPDR_PFX_SEG_DS: seg_code = `SPDR_SEG_DS;
      `SPDR_PFX_SEG_FS: seg_code = `SPDR_SEG_FS;
      default:          seg_code = `SPDR_SEG_GS;
    endcase
  end

  // ----------------------------------------------------------------
  // Prefix byte comparators
  // ----------------------------------------------------------------
  // One comparator per code keeps each recognised byte in plain sight
  spdr_byte_match #(
    .CODE (`SPDR_PFX_LOCK)
  ) lock_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_lock)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_ADDR)
  ) addr_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_addr)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_OPSZ)
  ) opsz_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_opsz)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_REP)
  ) rep_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_rep)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_REPNE)
  ) repne_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_repne)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_SEG_ES)
  ) es_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_es)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_SEG_CS)
  ) cs_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_cs)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_SEG_SS)
  ) ss_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_ss)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_SEG_DS)
  ) ds_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_ds)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_SEG_FS)
  ) fs_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_fs)
  );

  spdr_byte_match #(
    .CODE (`SPDR_PFX_SEG_GS)
  ) gs_match_u (
    .byte_i (pfx_byte_i),
    .hit_o  (hit_gs)
  );

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_ff     <= 1'b0;
      addr_ff     <= 1'b0;
      seg_ff      <= 1'b0;
      seg_id_ff   <= 3'h0;
      rsvd_ff     <= 1'b0;
      rex_ff      <= 1'b0;
      rex_bits_ff <= 4'h0;
    end else if (op_vld_i) begin
      lock_ff     <= 1'b0;
      addr_ff     <= 1'b0;
      seg_ff      <= 1'b0;
      rsvd_ff     <= 1'b0;
      rex_ff      <= 1'b0;
      rex_bits_ff <= 4'h0;
    end else if (pfx_vld_i) begin
      if (hit_lock) lock_ff <= 1'b1;
      if (hit_addr) addr_ff <= 1'b1;
      if (is_seg) begin
        seg_ff    <= 1'b1;
        seg_id_ff <= seg_code;
      end
      // Reserved prefixes only flagged; outcome undefined, so no fault
      if (hit_opsz || hit_rep || hit_repne) rsvd_ff <= 1'b1;
      if (is_rex) begin
        rex_ff      <= 1'b1;
        rex_bits_ff <= pfx_byte_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Packed registers alias the low 64 bits of the stack slots
  reg  [79:0]  fp_stack_ff [0:7];
  reg  [127:0] wide_ff     [0:15];
  reg  [31:0]  csr_ff;
  reg  [2:0]   top_ff;
  reg  [15:0]  tag_ff;

  wire [3:0]  wide_idx = {long_mode & rex_ff & rex_bits_ff[`SPDR_REX_R_BIT], op_reg_i};
  wire        csr_bad  = |(csr_wdata_i & `SPDR_CSR_RSVD_MASK);
  wire        do_op    = op_vld_i && !lock_ff;
  integer     i;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csr_ff <= `SPDR_CSR_RST;
      top_ff <= `SPDR_TOP_ZERO;
      tag_ff <= `SPDR_TAG_EMPTY;
      for (i = 0; i < 8; i = i + 1) begin
        fp_stack_ff[i] <= 80'h0;
      end
      for (i = 0; i < 16; i = i + 1) begin
        wide_ff[i] <= 128'h0;
      end
    end else if (do_op) begin
      if (op_pint_i) begin
        if (op_empty_i) begin
          tag_ff <= `SPDR_TAG_EMPTY;
        end else begin
          top_ff <= `SPDR_TOP_ZERO;
          tag_ff <= `SPDR_TAG_VALID;
          if (wr_en_i)
            fp_stack_ff[op_reg_i] <= {16'hFFFF, wr_data_i[63:0]};
        end
      end
      if (op_wide_i && wr_en_i && !op_cmp_i && !op_gpr_i) begin
        if (op_scalar_i)
          wide_ff[wide_idx][31:0] <= wr_data_i[31:0];
        else
          wide_ff[wide_idx] <= wr_data_i;
      end
      // Restore with reserved bits set is refused and left unchanged
      if (op_csr_ld_i && !csr_bad)
        csr_ff <= csr_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Decode results
  // ----------------------------------------------------------------
  assign dec_rdy_o = 1'b1;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ud_fault_o      <= 1'b0;
      gp_fault_o      <= 1'b0;
      rsvd_pfx_o      <= 1'b0;
      addr_ovr_o      <= 1'b0;
      seg_ovr_o       <= 1'b0;
      seg_sel_o       <= `SPDR_SEG_DS;
      dst_idx_o       <= 4'h0;
      gpr64_o         <= 1'b0;
      addr_from_gpr_o <= 1'b0;
      rd_data_o       <= 128'h0;
      flags_o         <= 32'h0;
      flags_wr_o      <= 1'b0;
      fq_edx_o        <= 32'h0;
    end else begin
      ud_fault_o      <= op_vld_i && op_pint_i && lock_ff;
      gp_fault_o      <= do_op && op_csr_ld_i && csr_bad;
      // Address and segment prefixes only steer memory forms
      rsvd_pfx_o      <= op_vld_i && (rsvd_ff || (!op_mem_i && (addr_ff || seg_ff)));
      addr_ovr_o      <= do_op && op_mem_i && addr_ff;
      seg_ovr_o       <= do_op && op_mem_i && seg_ff;
      seg_sel_o       <= (op_mem_i && seg_ff) ? seg_id_ff : `SPDR_SEG_DS;
      // Unused extension bits simply drop out here
      dst_idx_o       <= op_wide_i ? wide_idx : {1'b0, op_reg_i};
      gpr64_o         <= do_op && op_wide_i && op_gpr_i && rex_ff &&
                         rex_bits_ff[`SPDR_OPERAND_WIDTH_BIT_BIT];
      addr_from_gpr_o <= do_op && op_mem_i;
      if (op_vld_i) begin
        if (op_csr_st_i)
          rd_data_o <= {96'h0, csr_ff};
        else if (op_pint_i)
          rd_data_o <= {64'h0, fp_stack_ff[op_rm_i][63:0]};
        else if (op_scalar_i)
          rd_data_o <= {96'h0, wide_ff[{long_mode & rex_ff & rex_bits_ff[`SPDR_REX_B_BIT],
                                       op_rm_i}][31:0]};
        else
          rd_data_o <= wide_ff[{long_mode & rex_ff & rex_bits_ff[`SPDR_REX_B_BIT], op_rm_i}];
      end
      flags_wr_o      <= do_op && op_wide_i && op_cmp_i;
      flags_o         <= (do_op && op_wide_i && op_cmp_i) ? flags_res_i : flags_in_i;
      // Extension present in every mode, so bit is unconditional
      fq_edx_o        <= (fq_vld_i && fq_leaf_i == `SPDR_FQ_LEAF) ?
                         (32'h1 << `SPDR_FQ_EDX_BIT) : 32'h0;
    end
  end

  always @* begin
    csr_o = csr_ff;
    top_o = top_ff;
    tag_o = tag_ff;
  end

endmodule // spdr_decode

// ----------------------------------------------------------------
// Prefix byte comparator
// ----------------------------------------------------------------
module spdr_byte_match #(
  parameter [7:0] CODE = 8'h00
) (
  input  wire [7:0] byte_i,
  output wire       hit_o
);

  assign hit_o = (byte_i == CODE);

endmodule // spdr_byte_match
`default_nettype wire

// *** spdr_decode_asserts.sv ***
// Purpose: port-level checks on the SIMD prefix decode block
// Assumes: one core clock, nrst_i asynchronous and active low
// Notes:   bound to every spdr_decode instance
`timescale 1ns/100ps
`default_nettype none
module spdr_decode_chk (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [1:0]  mode_i,
  input wire logic        compat_i,
  input wire logic        pfx_vld_i,
  input wire logic [7:0]  pfx_byte_i,
  input wire logic        op_vld_i,
  input wire logic        op_pint_i,
  input wire logic        op_wide_i,
  input wire logic        op_empty_i,
  input wire logic        op_mem_i,
  input wire logic        op_cmp_i,
  input wire logic        op_csr_ld_i,
  input wire logic [2:0]  op_reg_i,
  input wire logic [31:0] csr_wdata_i,
  input wire logic [31:0] flags_res_i,
  input wire logic        fq_vld_i,
  input wire logic [31:0] fq_leaf_i,
  input wire logic        ud_fault_o,
  input wire logic        gp_fault_o,
  input wire logic [3:0]  dst_idx_o,
  input wire logic        addr_from_gpr_o,
  input wire logic [31:0] flags_o,
  input wire logic        flags_wr_o,
  input wire logic [31:0] fq_edx_o,
  input wire logic [31:0] csr_o,
  input wire logic [2:0]  top_o,
  input wire logic [15:0] tag_o
);
  // ------------------------------------------
  // Lock prefix seen since the last opcode
  // ------------------------------------------
  logic lock_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      lock_ff <= 1'b0;
    else if (op_vld_i)
      lock_ff <= 1'b0;
    else if (pfx_vld_i && pfx_byte_i == 8'hF0)
      lock_ff <= 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_lock_op;
    pfx_vld_i && !op_vld_i && pfx_byte_i == 8'hF0 ##1 op_vld_i && op_pint_i;
  endsequence
  // Both cycles must sit in long mode, else the prefix is dropped
  sequence s_ext_op;
    pfx_vld_i && !op_vld_i && pfx_byte_i == 8'h44 && mode_i == 2'h3 && !compat_i
      ##1 op_vld_i && op_wide_i && mode_i == 2'h3 && !compat_i;
  endsequence

  a_lock_fault: assert property (s_lock_op |=> ud_fault_o)
    else $error("locked packed op raised no fault");
  a_fault_cause: assert property (ud_fault_o |-> $past(op_vld_i) && $past(op_pint_i)
    && $past(lock_ff)) else $error("fault without locked packed op");
  a_fq_report: assert property (fq_vld_i && fq_leaf_i == 32'h00000001 |=> fq_edx_o[25])
    else $error("feature bit missing");
  a_narrow_idx: assert property (op_vld_i && (mode_i != 2'h3 || compat_i) |=>
    dst_idx_o[3] == 1'b0) else $error("upper register outside long mode");
  a_ext_idx: assert property (s_ext_op |=> dst_idx_o == {1'b1, $past(op_reg_i)})
    else $error("extension index bit not applied");
  a_pint_state: assert property (op_vld_i && op_pint_i && !op_empty_i && !lock_ff |=>
    top_o == 3'h0 && tag_o == 16'h0000) else $error("packed op left stack state");
  a_csr_guard: assert property (op_vld_i && op_csr_ld_i && csr_wdata_i[31:16] != 16'h0000
    && !lock_ff |=> gp_fault_o && csr_o == $past(csr_o)) else $error("bad restore accepted");
  a_addr_src: assert property (op_vld_i && !lock_ff |=>
    addr_from_gpr_o == $past(op_mem_i)) else $error("address source wrong");
  a_cmp_flags: assert property (op_vld_i && op_wide_i && op_cmp_i && !lock_ff |=>
    flags_wr_o && flags_o == $past(flags_res_i)) else $error("compare flags wrong");
endmodule // spdr_decode_chk

bind spdr_decode spdr_decode_chk chk_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .compat_i(compat_i),
  .pfx_vld_i(pfx_vld_i), .pfx_byte_i(pfx_byte_i), .op_vld_i(op_vld_i),
  .op_pint_i(op_pint_i), .op_wide_i(op_wide_i), .op_empty_i(op_empty_i),
  .op_mem_i(op_mem_i), .op_cmp_i(op_cmp_i), .op_csr_ld_i(op_csr_ld_i),
  .op_reg_i(op_reg_i), .csr_wdata_i(csr_wdata_i), .flags_res_i(flags_res_i),
  .fq_vld_i(fq_vld_i), .fq_leaf_i(fq_leaf_i), .ud_fault_o(ud_fault_o),
  .gp_fault_o(gp_fault_o), .dst_idx_o(dst_idx_o), .addr_from_gpr_o(addr_from_gpr_o),
  .flags_o(flags_o), .flags_wr_o(flags_wr_o), .fq_edx_o(fq_edx_o), .csr_o(csr_o),
  .top_o(top_o), .tag_o(tag_o)
);
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the SIMD prefix decode block
// Assumes: results appear one edge after each opcode or query strobe
// Notes:   driver queues notes, a negedge monitor compares them
`timescale 1ns/100ps
`default_nettype none
`include "spdr_defs.vh"
module tb_top;
  typedef struct {int grp; int sel; logic [127:0] exp;} spdr_note_t;
  localparam logic [8:0] FP = 9'h100, FW = 9'h080, FE = 9'h040, FM = 9'h020;
  localparam logic [8:0] FG = 9'h010, FS = 9'h008, FC = 9'h004, FL = 9'h002, FR = 9'h001;
  logic clk_i = 0, nrst_i = 0, pfx_vld_i = 0, op_vld_i = 0, fq_vld_i = 0, compat_i = 0;
  logic op_pint_i = 0, op_wide_i = 0, op_empty_i = 0, op_mem_i = 0, op_gpr_i = 0;
  logic op_scalar_i = 0, op_cmp_i = 0, op_csr_ld_i = 0, op_csr_st_i = 0, wr_en_i = 0;
  logic [1:0] mode_i = 0;
  logic [7:0] pfx_byte_i = 0;
  logic [2:0] op_reg_i = 0, op_rm_i = 0, seg_sel_o, top_o;
  logic [127:0] wr_data_i = 0, rd_data_o;
  logic [31:0] csr_wdata_i = 0, flags_in_i = 0, flags_res_i = 0, fq_leaf_i = 0;
  logic ud_fault_o, gp_fault_o, rsvd_pfx_o, addr_ovr_o, seg_ovr_o, gpr64_o;
  logic addr_from_gpr_o, flags_wr_o, dec_rdy_o, d1 = 0;
  logic [3:0] dst_idx_o;
  logic [31:0] flags_o, fq_edx_o, csr_o, v;
  logic [15:0] tag_o;
  logic [7:0] segs [6] = '{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65};
  logic [7:0] bad [5] = '{8'h66, 8'hF3, 8'hF2, 8'h67, 8'h2E};
  string nm [17] = '{"ud", "rsvd", "dst", "edx", "top", "tag", "csr", "gp", "seg",
    "flags", "agpr", "gpr64", "aovr", "sovr", "fwr", "rd", "rdy"};
  spdr_note_t notes [$];
  spdr_note_t nt;
  logic [127:0] d = 0, e = 0;
  logic [2:0] rs = 0;
  int n_ops = 0, seen = 0, miscompares = 0, samples_checked = 0;

  spdr_decode dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .compat_i(compat_i),
    .pfx_vld_i(pfx_vld_i), .pfx_byte_i(pfx_byte_i), .op_vld_i(op_vld_i),
    .op_pint_i(op_pint_i), .op_wide_i(op_wide_i), .op_empty_i(op_empty_i),
    .op_mem_i(op_mem_i), .op_gpr_i(op_gpr_i), .op_scalar_i(op_scalar_i),
    .op_cmp_i(op_cmp_i), .op_csr_ld_i(op_csr_ld_i), .op_csr_st_i(op_csr_st_i),
    .op_reg_i(op_reg_i), .op_rm_i(op_rm_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
    .csr_wdata_i(csr_wdata_i), .flags_in_i(flags_in_i), .flags_res_i(flags_res_i),
    .fq_vld_i(fq_vld_i), .fq_leaf_i(fq_leaf_i), .ud_fault_o(ud_fault_o),
    .gp_fault_o(gp_fault_o), .rsvd_pfx_o(rsvd_pfx_o), .addr_ovr_o(addr_ovr_o),
    .seg_ovr_o(seg_ovr_o), .seg_sel_o(seg_sel_o), .dst_idx_o(dst_idx_o),
    .gpr64_o(gpr64_o), .addr_from_gpr_o(addr_from_gpr_o), .rd_data_o(rd_data_o),
    .flags_o(flags_o), .flags_wr_o(flags_wr_o), .fq_edx_o(fq_edx_o), .csr_o(csr_o),
    .top_o(top_o), .tag_o(tag_o), .dec_rdy_o(dec_rdy_o)
  );

  always #4 clk_i = ~clk_i;

  function automatic logic [127:0] obs(int s);
    case (s)
      0: obs = ud_fault_o;
      1: obs = rsvd_pfx_o;
      2: obs = dst_idx_o;
      3: obs = fq_edx_o;
      4: obs = top_o;
      5: obs = tag_o;
      6: obs = csr_o;
      7: obs = gp_fault_o;
      8: obs = seg_sel_o;
      9: obs = flags_o;
      10: obs = addr_from_gpr_o;
      11: obs = gpr64_o;
      12: obs = addr_ovr_o;
      13: obs = seg_ovr_o;
      14: obs = flags_wr_o;
      15: obs = rd_data_o;
      default: obs = dec_rdy_o;
    endcase
  endfunction

  task automatic cmp(string n, logic [127:0] e, logic [127:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic note(int s, logic [127:0] e);
    notes.push_back('{n_ops, s, e});
  endtask

  task automatic strobe(logic p, logic o, logic q);
    pfx_vld_i <= p;
    op_vld_i <= o;
    fq_vld_i <= q;
  endtask

  task automatic pfx(logic [7:0] b);
    @(posedge clk_i);
    strobe(1, 0, 0);
    pfx_byte_i <= b;
  endtask

  task automatic op(logic [8:0] f, logic [2:0] r, logic [31:0] w);
    @(posedge clk_i);
    d = {$urandom, $urandom, $urandom, $urandom};
    strobe(0, 1, 0);
    {op_pint_i, op_wide_i, op_empty_i, op_mem_i, op_gpr_i, op_scalar_i, op_cmp_i,
      op_csr_ld_i, op_csr_st_i} <= f;
    wr_en_i <= f[8] | f[7];
    op_reg_i <= r;
    op_rm_i <= rs;
    wr_data_i <= d;
    csr_wdata_i <= w;
    flags_res_i <= w;
    n_ops++;
  endtask

  task automatic fq(logic [31:0] l);
    @(posedge clk_i);
    strobe(0, 0, 1);
    fq_leaf_i <= l;
    n_ops++;
  endtask

  task automatic setm(logic [1:0] m, logic c);
    @(posedge clk_i);
    strobe(0, 0, 0);
    mode_i <= m;
    compat_i <= c;
  endtask

  task automatic give_verdict;
    if (notes.size() != 0)
      miscompares++;
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------
  // Monitor: one group of notes per strobe
  // ------------------------------------------
  always @(posedge clk_i) d1 <= op_vld_i | fq_vld_i;
  always @(negedge clk_i) begin
    if (d1) begin
      while (notes.size() > 0 && notes[0].grp == seen) begin
        nt = notes.pop_front();
        cmp(nm[nt.sel], nt.exp, obs(nt.sel));
      end
      seen++;
    end
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end

  initial begin
    void'($urandom(32'hE259B056));
    repeat (8) @(posedge clk_i);
    cmp("rst_csr", `SPDR_CSR_RST, csr_o);
    cmp("rst_tag", `SPDR_TAG_EMPTY, tag_o);
    nrst_i <= 1;
    setm(2'h1, 0);
    note(0, 1); note(5, 16'hFFFF); pfx(8'hF0); op(FP, 3'h3, 0);
    note(0, 0); note(4, 0); note(5, 0); note(10, 0); op(FP, 3'h1, 0);
    e = d;
    note(5, 16'hFFFF); op(FP | FE, 3'h0, 0);
    rs = 3'h1;
    note(15, e[63:0]); note(16, 1); op(FP, 3'h6, 0);
    foreach (bad[i]) begin
      note(1, 1); note(12, 0); note(13, 0); pfx(bad[i]); op(FP, 3'h2, 0);
    end
    note(1, 0); note(10, 1); note(12, 1); pfx(8'h67); op(FP | FM, 3'h2, 0);
    foreach (segs[i]) begin
      note(8, i); note(1, 0); note(13, 1); pfx(segs[i]); op(FP | FM, 3'h4, 0);
    end
    for (int m = 0; m < 4; m++) begin
      setm(m[1:0], m == 3);
      v = $urandom;
      note(0, 0); note(2, {1'b0, v[2:0]}); pfx(8'h44); op(FW, v[2:0], 0);
    end
    setm(2'h3, 0);
    note(2, {1'b1, v[2:0]}); pfx(8'h44); op(FW, v[2:0], 0);
    note(2, {1'b0, v[2:0]}); op(FW, v[2:0], 0);
    note(0, 0); note(2, {1'b0, v[2:0]}); pfx(8'h40); op(FW, v[2:0], 0);
    note(11, 1); note(14, 0); pfx(8'h48); op(FW | FG, 3'h1, 0);
    rs = 3'h2;
    pfx(8'h44); op(FW, 3'h2, 0);
    e = d;
    note(15, e); pfx(8'h41); op(FW, 3'h6, 0);
    pfx(8'h44); op(FW | FS, 3'h2, 0);
    note(15, {e[127:32], d[31:0]}); pfx(8'h41); op(FW, 3'h6, 0);
    v = $urandom & 32'h0000FFFF;
    note(6, v); note(7, 0); op(FL, 3'h0, v);
    note(6, v); note(7, 1); op(FL, 3'h0, v | 32'h00010000);
    note(15, v); op(FR, 3'h0, 0);
    v = $urandom;
    note(9, v); note(14, 1); op(FW | FC, 3'h0, v);
    note(3, 32'h02000000); fq(32'h00000001);
    note(3, 0); fq(32'h00000002);
    setm(2'h1, 0);
    repeat (3) @(posedge clk_i);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
